// [rtl/byte_op_skip_branch_exec.sv]
// Purpose: Executes decrement, clear, skip-on-zero, branch and OR-literal instructions.
// Assumes: The file register array answers a read address in the same cycle.
// Notes: A zero skip result or a branch turns the following instruction slot into a no-operation.
// Function
// RULE1 - Decrement-file subtracts one from file f and writes W or f by d, updating zero.
// RULE2 - Clear-working loads W with 00h and sets the zero flag.
// RULE3 - Decrement-skip subtracts one from file f, writes W or f by d, flags unchanged.
// RULE4 - A zero decrement-skip result makes the next slot a no-operation, two cycles.
// RULE5 - Increment-skip adds one to file f, writes W or f by d, flags unchanged.
// RULE6 - A zero increment-skip result makes the next slot a no-operation, two cycles.
// RULE7 - The branch loads its 11-bit literal into program counter bits 10 to 0, no flags.
// RULE8 - The branch fills program counter bits 14 to 11 from latch bits 6 to 3.
// RULE9 - The branch always takes two cycles, the next fetched slot not executing.
// RULE10 - OR-literal ORs an 8-bit literal into W and updates the zero flag.
// RULE11 - A decrement-file or OR-literal result sets zero when the 8-bit result is zero and clears it otherwise.
`timescale 1ns/1ps

module byte_op_skip_branch_exec (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [byte_op_pkg::INSTR_W-1:0] instr_i,
  input wire logic instr_valid_i,
  input wire logic [byte_op_pkg::DATA_W-1:0] file_rdata_i,
  input wire logic [byte_op_pkg::LATCH_W-1:0] program_counter_latch_high_i,
  output logic instr_ready_o,
  output logic [byte_op_pkg::FADDR_W-1:0] file_raddr_o,
  output logic file_we_o,
  output logic [byte_op_pkg::FADDR_W-1:0] file_waddr_o,
  output logic [byte_op_pkg::DATA_W-1:0] file_wdata_o,
  output logic [byte_op_pkg::DATA_W-1:0] working_o,
  output logic zero_o,
  output logic pc_load_o,
  output logic [byte_op_pkg::PC_W-1:0] pc_target_o,
  output logic flush_o
);
  import byte_op_pkg::*;

  exec_state_t state_r;
  exec_state_t state_nxt;
  logic [5:0] opc;
  logic [2:0] br_opc;
  logic dest;
  logic take;
  logic decrement_file_op;
  logic clear_working_op;
  logic decrement_skip_zero_op;
  logic increment_skip_zero_op;
  logic or_literal_working_op;
  logic unconditional_branch_op;
  logic file_op;
  logic skip;
  logic [7:0] dec_res;
  logic [7:0] inc_res;
  logic [7:0] or_res;
  logic [7:0] file_res;
  logic [7:0] working_r;
  logic zero_r;
  logic file_we_r;
  logic [6:0] file_waddr_r;
  logic [7:0] file_wdata_r;
  logic pc_load_r;
  logic [14:0] pc_target_r;

  // Instruction field decode.
  assign opc = instr_i[OPC_MSB:OPC_LSB];
  assign br_opc = instr_i[OPC_MSB:BR_OPC_LSB];
  assign dest = instr_i[DEST_POS];
  assign file_raddr_o = instr_i[FADDR_MSB:0];

  // An instruction is taken only in the run state; a flushed slot is dropped.
  assign take = (state_r == ST_RUN) && instr_valid_i;
  assign instr_ready_o = (state_r == ST_RUN);
  assign flush_o = (state_r == ST_FLUSH);

  assign decrement_file_op = take && (opc == OP_DECREMENT_FILE);
  assign clear_working_op = take && (opc == OP_CLEAR_WORKING);
  assign decrement_skip_zero_op = take && (opc == OP_DECREMENT_SKIP);
  assign increment_skip_zero_op = take && (opc == OP_INCREMENT_SKIP);
  assign or_literal_working_op = take && (opc == OP_OR_LITERAL);
  assign unconditional_branch_op = take && (br_opc == OP_BRANCH);

  // Datapath results.
  assign dec_res = file_rdata_i - STEP_ONE; // see RULE1 see RULE3
  assign inc_res = file_rdata_i + STEP_ONE; // see RULE5
  assign or_res = working_r | instr_i[LIT_MSB:0]; // see RULE10
  assign file_res = increment_skip_zero_op ? inc_res : dec_res;
  assign file_op = decrement_file_op || decrement_skip_zero_op || increment_skip_zero_op;
  assign skip = (decrement_skip_zero_op || increment_skip_zero_op)
                && is_zero(file_res); // see RULE4 see RULE6

  // A zero skip result or any branch turns the next slot into a no-operation.
  always_comb begin
    case (state_r)
      ST_RUN: begin
        if (skip || unconditional_branch_op) begin // see RULE4 see RULE6 see RULE9
          state_nxt = ST_FLUSH;
        end else begin
          state_nxt = ST_RUN;
        end
      end
      ST_FLUSH: begin
        state_nxt = ST_RUN;
      end
      default: begin
        state_nxt = ST_RUN;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= ST_RUN;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Working register.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      working_r <= WORKING_RESET;
    end else if (file_op && !dest) begin
      working_r <= file_res; // see RULE1 see RULE3 see RULE5
    end else if (clear_working_op) begin
      working_r <= CLEAR_VALUE; // see RULE2
    end else if (or_literal_working_op) begin
      working_r <= or_res; // see RULE10
    end
  end

  // Zero flag; skip and branch instructions leave it alone.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      zero_r <= ZERO_RESET;
    end else if (decrement_file_op) begin
      zero_r <= is_zero(dec_res); // see RULE1 see RULE11
    end else if (clear_working_op) begin
      zero_r <= 1'b1; // see RULE2
    end else if (or_literal_working_op) begin
      zero_r <= is_zero(or_res); // see RULE10 see RULE11
    end
  end

  // File register write-back, one cycle after execution.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      file_we_r <= 1'b0;
      file_waddr_r <= FADDR_RESET;
      file_wdata_r <= CLEAR_VALUE;
    end else begin
      file_we_r <= file_op && dest; // see RULE1 see RULE3 see RULE5
      if (file_op) begin
        file_waddr_r <= instr_i[FADDR_MSB:0];
        file_wdata_r <= file_res;
      end
    end
  end

  // Program counter load on a branch.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pc_load_r <= 1'b0;
      pc_target_r <= PC_TARGET_RESET;
    end else begin
      pc_load_r <= unconditional_branch_op;
      if (unconditional_branch_op) begin
        pc_target_r <= {program_counter_latch_high_i[LATCH_UP_MSB:LATCH_UP_LSB], // see RULE8
                        instr_i[BR_LIT_MSB:0]}; // see RULE7
      end
    end
  end

  assign working_o = working_r;
  assign zero_o = zero_r;
  assign file_we_o = file_we_r;
  assign file_waddr_o = file_waddr_r;
  assign file_wdata_o = file_wdata_r;
  assign pc_load_o = pc_load_r;
  assign pc_target_o = pc_target_r;

  // Checks.
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  chk_dec_to_working: assert property ( // see RULE1
    decrement_file_op && !dest |=> working_o == 8'($past(file_rdata_i) - 8'h01)
      && !file_we_o)
    else $error("Decrement to working register gave a wrong value.");

  chk_dec_to_file: assert property ( // see RULE1
    decrement_file_op && dest |=> file_we_o && file_waddr_o == $past(instr_i[6:0])
      && file_wdata_o == 8'($past(file_rdata_i) - 8'h01) && $stable(working_o))
    else $error("Decrement to file wrote a wrong value or changed the working register.");

  chk_dec_no_flush: assert property ( // see RULE1
    decrement_file_op |=> !flush_o && !pc_load_o)
    else $error("Decrement flushed the next slot or loaded the counter.");

  chk_write_only_file: assert property ( // see RULE1
    !file_op |=> !file_we_o)
    else $error("A file write came from an instruction that does not write files.");

  chk_dec_zero_flag: assert property ( // see RULE11
    decrement_file_op |=> zero_o == ($past(file_rdata_i) == 8'h01))
    else $error("Decrement did not set the zero flag from its result.");

  chk_clear_working: assert property ( // see RULE2
    clear_working_op |=> working_o == 8'h00 && zero_o)
    else $error("Clear working did not clear the register and set zero.");

  chk_clear_side_effects: assert property ( // see RULE2
    clear_working_op |=> !file_we_o && !flush_o && !pc_load_o)
    else $error("Clear working wrote a file, flushed a slot or loaded the counter.");

  chk_skip_flags_kept: assert property ( // see RULE3
    (decrement_skip_zero_op || increment_skip_zero_op) |=> $stable(zero_o))
    else $error("A skip instruction changed the zero flag.");

  chk_dec_skip_working: assert property ( // see RULE3
    decrement_skip_zero_op && !dest |=> working_o == 8'($past(file_rdata_i) - 8'h01)
      && !file_we_o)
    else $error("Decrement-skip to working register gave a wrong value.");

  chk_dec_skip_file: assert property ( // see RULE3
    decrement_skip_zero_op && dest |=> file_we_o && file_waddr_o == $past(instr_i[6:0])
      && file_wdata_o == 8'($past(file_rdata_i) - 8'h01) && $stable(working_o))
    else $error("Decrement-skip write-back to file was wrong.");

  chk_dec_skip_once: assert property ( // see RULE4
    decrement_skip_zero_op && file_rdata_i == 8'h01 |=> flush_o && !instr_ready_o
      ##1 !flush_o)
    else $error("Zero decrement-skip result did not flush exactly one slot.");

  chk_dec_skip_none: assert property ( // see RULE4
    decrement_skip_zero_op && file_rdata_i != 8'h01 |=> !flush_o)
    else $error("Nonzero decrement-skip result flushed the next slot.");

  chk_no_op_slot: assert property ( // see RULE4
    flush_o |=> $stable(working_o) && $stable(zero_o) && !file_we_o && !pc_load_o)
    else $error("The flushed slot changed state instead of acting as a no-operation.");

  chk_inc_skip_file: assert property ( // see RULE5
    increment_skip_zero_op && dest |=> file_we_o
      && file_wdata_o == 8'($past(file_rdata_i) + 8'h01)
      && file_waddr_o == $past(instr_i[6:0]))
    else $error("Increment-skip write-back to file was wrong.");

  chk_inc_keeps_working: assert property ( // see RULE5
    increment_skip_zero_op && dest |=> $stable(working_o))
    else $error("Increment-skip to file changed the working register.");

  chk_inc_skip_working: assert property ( // see RULE5
    increment_skip_zero_op && !dest |=> working_o == 8'($past(file_rdata_i) + 8'h01)
      && !file_we_o)
    else $error("Increment-skip to working register gave a wrong value.");

  chk_inc_skip_zero: assert property ( // see RULE6
    increment_skip_zero_op |=> flush_o == ($past(file_rdata_i) == 8'hff))
    else $error("Increment-skip flush did not follow the zero result.");

  chk_flush_one_slot: assert property ( // see RULE6
    flush_o |=> !flush_o)
    else $error("More than one slot in a row was flushed.");

  chk_branch_target: assert property ( // see RULE7
    unconditional_branch_op |=> pc_load_o && pc_target_o[10:0] == $past(instr_i[10:0]))
    else $error("Branch did not load the literal into the low counter bits.");

  chk_branch_no_write: assert property ( // see RULE7
    unconditional_branch_op |=> !file_we_o)
    else $error("Branch wrote a file register.");

  chk_load_only_branch: assert property ( // see RULE7
    !unconditional_branch_op |=> !pc_load_o)
    else $error("The counter was loaded without a branch.");

  chk_target_held: assert property ( // see RULE7
    !unconditional_branch_op |=> $stable(pc_target_o))
    else $error("The branch target changed without a branch.");

  chk_branch_upper: assert property ( // see RULE8
    unconditional_branch_op |=> pc_target_o[14:11]
      == $past(program_counter_latch_high_i[6:3]))
    else $error("Branch upper counter bits did not come from the latch.");

  chk_branch_two_cycles: assert property ( // see RULE9
    unconditional_branch_op |=> flush_o && $stable(zero_o) && $stable(working_o)
      ##1 instr_ready_o)
    else $error("Branch did not take exactly two cycles without side effects.");

  chk_load_one_cycle: assert property ( // see RULE9
    pc_load_o |=> !pc_load_o)
    else $error("The counter load lasted more than one cycle.");

  chk_or_literal: assert property ( // see RULE10
    or_literal_working_op |=> working_o == ($past(working_o) | $past(instr_i[7:0]))
      && zero_o == (working_o == 8'h00))
    else $error("OR literal gave a wrong working value or zero flag.");

  chk_or_side_effects: assert property ( // see RULE10
    or_literal_working_op |=> !file_we_o && !flush_o && !pc_load_o)
    else $error("OR literal wrote a file, flushed a slot or loaded the counter.");

  chk_or_nonzero_flag: assert property ( // see RULE11
    or_literal_working_op && instr_i[7:0] != 8'h00 |=> !zero_o)
    else $error("OR literal with a nonzero literal left the zero flag set.");

  cov_dec_skip: cover property (decrement_skip_zero_op && file_rdata_i == 8'h01);
  cov_inc_run_on: cover property (increment_skip_zero_op && file_rdata_i != 8'hff && dest);
  cov_inc_skip_working: cover property (increment_skip_zero_op && file_rdata_i == 8'hff
    && !dest);
  cov_branch: cover property (unconditional_branch_op ##2 take);
  cov_or_zero: cover property (or_literal_working_op && working_r == 8'h00
    && instr_i[7:0] == 8'h00);

endmodule // byte_op_skip_branch_exec

// [include/byte_op_pkg.sv]
// Purpose: Shared constants, types and helpers for the byte-op, skip and branch executor.
// Assumes: 14-bit instruction words, 8-bit data, 7-bit file addresses, 15-bit program counter.
// Notes: Opcode values below are a local encoding of this core.
package byte_op_pkg;

  localparam int INSTR_W = 14;
  localparam int DATA_W = 8;
  localparam int FADDR_W = 7;
  localparam int PC_W = 15;
  localparam int LATCH_W = 7;
  localparam int BR_LIT_W = 11;
  localparam int UPPER_W = 4;

  // Field positions inside the instruction word.
  localparam int OPC_MSB = 13;
  localparam int OPC_LSB = 8;
  localparam int BR_OPC_LSB = 11;
  localparam int DEST_POS = 7;
  localparam int FADDR_MSB = 6;
  localparam int LIT_MSB = 7;
  localparam int BR_LIT_MSB = 10;

  // Latch bits that feed the upper program counter bits on a branch.
  localparam int LATCH_UP_MSB = 6;
  localparam int LATCH_UP_LSB = 3;

  // Opcodes.
  localparam logic [5:0] OP_CLEAR_WORKING = 6'h01;
  localparam logic [5:0] OP_DECREMENT_FILE = 6'h03;
  localparam logic [5:0] OP_DECREMENT_SKIP = 6'h0b;
  localparam logic [5:0] OP_INCREMENT_SKIP = 6'h0f;
  localparam logic [5:0] OP_OR_LITERAL = 6'h38;
  localparam logic [2:0] OP_BRANCH = 3'h5;

  // Values after reset and constant results.
  localparam logic [7:0] WORKING_RESET = 8'h00;
  localparam logic [7:0] CLEAR_VALUE = 8'h00;
  localparam logic [7:0] STEP_ONE = 8'h01;
  localparam logic ZERO_RESET = 1'b0;
  localparam logic [14:0] PC_TARGET_RESET = 15'h0000;
  localparam logic [6:0] FADDR_RESET = 7'h00;

  typedef enum logic [0:0] {
    ST_RUN = 1'b0,
    ST_FLUSH = 1'b1
  } exec_state_t;

  // Zero test of an 8-bit result.
  function automatic logic is_zero(input logic [7:0] value);
    is_zero = (value == 8'h00);
  endfunction

endpackage

// [test/byte_op_skip_branch_exec_tb_top.sv]
// Purpose: Self-checking bench for the byte-op, skip and branch executor.
// Assumes: The bench answers file reads itself and drives inputs at the rising edge.
// Notes: A reference model in integers predicts every result; the slot after a skip is probed.
`timescale 1ns/1ps

module byte_op_skip_branch_exec_tb_top;
  import byte_op_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [13:0] instr_i = 14'h0000;
  logic instr_valid_i = 1'b0;
  logic [7:0] file_rdata_i = 8'h00;
  logic [6:0] program_counter_latch_high_i = 7'h00;
  logic instr_ready_o, file_we_o, zero_o, pc_load_o, flush_o;
  logic [6:0] file_raddr_o, file_waddr_o;
  logic [7:0] file_wdata_o, working_o;
  logic [14:0] pc_target_o;
  int mismatches = 0;
  int n_checks = 0;
  int w_m = 0;
  int z_m = 0;
  int tgt_m = 0;
  // The random sequence starts at 6768.
  logic [15:0] seed = 16'h1a70;
  logic [5:0] ops [8] = '{OP_CLEAR_WORKING, OP_DECREMENT_FILE, OP_DECREMENT_SKIP,
    OP_INCREMENT_SKIP, OP_OR_LITERAL, {OP_BRANCH, 3'h0}, 6'h3f, OP_DECREMENT_SKIP};

  byte_op_skip_branch_exec u_byte_op_skip_branch_exec (
    .clk_i(clk_i), .rst_i(rst_i), .instr_i(instr_i), .instr_valid_i(instr_valid_i),
    .file_rdata_i(file_rdata_i), .program_counter_latch_high_i(program_counter_latch_high_i),
    .instr_ready_o(instr_ready_o), .file_raddr_o(file_raddr_o), .file_we_o(file_we_o),
    .file_waddr_o(file_waddr_o), .file_wdata_o(file_wdata_o), .working_o(working_o),
    .zero_o(zero_o), .pc_load_o(pc_load_o), .pc_target_o(pc_target_o), .flush_o(flush_o)
  );

  initial begin
    forever #20 clk_i = ~clk_i;
  end

  function automatic logic [15:0] next_rand(input logic [15:0] s);
    next_rand = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic check(input logic ok, input string what);
    n_checks++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("unexpected at %0t: %s", $time, what);
    end
  endtask

  task automatic finish_test();
    if (mismatches == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Predicts one instruction, presents it, and probes the slot after it with an ignored clear.
  task automatic step(input logic [13:0] ins, input logic [7:0] rd, input logic [6:0] lat);
    int r;
    logic we_e, pl_e, fl_e;
    we_e = 1'b0;
    pl_e = 1'b0;
    fl_e = 1'b0;
    r = -1;
    if (ins[13:11] == OP_BRANCH) begin
      pl_e = 1'b1;
      fl_e = 1'b1;
      tgt_m = {lat[LATCH_UP_MSB:LATCH_UP_LSB], ins[10:0]};
    end else begin
      case (ins[13:8])
        OP_CLEAR_WORKING: begin
          w_m = 0;
          z_m = 1;
        end
        OP_DECREMENT_FILE, OP_DECREMENT_SKIP: r = (rd + 255) % 256;
        OP_INCREMENT_SKIP: r = (rd + 1) % 256;
        OP_OR_LITERAL: begin
          w_m = w_m | ins[7:0];
          z_m = (w_m == 0);
        end
        default: ;
      endcase
    end
    if (r >= 0) begin
      if (ins[7]) we_e = 1'b1;
      else w_m = r;
      if (ins[13:8] == OP_DECREMENT_FILE) z_m = (r == 0);
      else fl_e = (r == 0);
    end
    @(posedge clk_i);
    instr_i <= ins;
    instr_valid_i <= 1'b1;
    file_rdata_i <= rd;
    program_counter_latch_high_i <= lat;
    #1;
    check(file_raddr_o === ins[6:0], "read address");
    @(posedge clk_i);
    instr_valid_i <= fl_e;
    instr_i <= {OP_CLEAR_WORKING, 8'h00};
    #1;
    check(file_we_o === we_e, "write strobe");
    if (we_e) check(file_waddr_o === ins[6:0] && file_wdata_o === r[7:0], "write data");
    check(working_o === w_m[7:0], "working value");
    check(zero_o === z_m[0], "zero flag");
    check(pc_load_o === pl_e && pc_target_o === tgt_m[14:0], "branch target");
    check(flush_o === fl_e && instr_ready_o === !fl_e, "skip slot");
  endtask

  initial begin
    #(40 * 4000);
    mismatches++;
    finish_test();
  end

  initial begin
    logic [15:0] a;
    logic [13:0] ins;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    #1;
    check(working_o === WORKING_RESET && zero_o === ZERO_RESET && file_we_o === 1'b0
      && pc_load_o === 1'b0 && flush_o === 1'b0 && instr_ready_o === 1'b1
      && pc_target_o === PC_TARGET_RESET && file_waddr_o === FADDR_RESET
      && file_wdata_o === CLEAR_VALUE, "reset state");
    step({OP_CLEAR_WORKING, 8'h00}, 8'h5a, 7'h00);
    step({OP_OR_LITERAL, 8'h00}, 8'h00, 7'h00);
    step({OP_OR_LITERAL, 8'h80}, 8'h00, 7'h00);
    step({OP_DECREMENT_FILE, 1'b0, 7'h7f}, 8'h00, 7'h00);
    step({OP_DECREMENT_FILE, 1'b1, 7'h00}, 8'h01, 7'h00);
    step({OP_DECREMENT_SKIP, 1'b1, 7'h01}, 8'h01, 7'h00);
    step({OP_DECREMENT_SKIP, 1'b0, 7'h7f}, 8'h00, 7'h00);
    step({OP_INCREMENT_SKIP, 1'b0, 7'h05}, 8'hff, 7'h00);
    step({OP_INCREMENT_SKIP, 1'b1, 7'h7f}, 8'h7f, 7'h00);
    step({OP_BRANCH, 11'h7ff}, 8'h00, 7'h7f);
    step({OP_BRANCH, 11'h000}, 8'h00, 7'h07);
    for (int i = 0; i < 300; i++) begin
      seed = next_rand(seed);
      a = seed;
      seed = next_rand(seed);
      ins = {ops[a[2:0]], seed[7:0]};
      if (ins[13:11] == OP_BRANCH) ins[10:0] = seed[10:0];
      step(ins, a[5] ? a[15:8] : (a[6] ? 8'h01 : 8'hff), seed[14:8]);
    end
    finish_test();
  end
endmodule  // byte_op_skip_branch_exec_tb_top
